//--- logic/fsp_segment_protect.v
`include "fsp_map.vh"
`default_nettype none
module fsp_segment_protect #(
  parameter IS_32K = 1
) (
  input  wire        clk_sys,
  input  wire        reset,
  input  wire [7:0]  boot_segment_config,
  input  wire [7:0]  general_segment_config,
  input  wire [1:0]  debug_channel_sel,
  input  wire        debug_enable,
  input  wire [23:0] prog_addr,
  input  wire [15:0] ram_addr,
  input  wire [2:0]  prog_debug_clock_pin,
  input  wire [2:0]  prog_debug_data_pin_in,
  input  wire        master_clear_pin_n,
  input  wire        link_data_out,
  input  wire        link_data_oe,
  output reg  [2:0]  prog_debug_data_pin_out,
  output reg  [2:0]  prog_debug_data_pin_oe,
  output reg  [1:0]  segment_class_q,
  output reg         addr_invalid_q,
  output reg         boot_protect_q,
  output reg         general_protect_q,
  output reg  [23:0] boot_end_q,
  output reg         ram_reserved_q,
  output reg  [1:0]  pins_reserved_q,
  output reg         link_clock_q,
  output reg         link_clock_rise_q,
  output reg         link_clock_fall_q,
  output reg         link_data_q,
  output reg         master_clear_active_q,
  output reg         channel_error_q
);

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // boot end address per size code; zero means no boot segment
  function [23:0] boot_end_of;
    input [1:0] bss;
    begin
      case (bss)
        `FSP_BSS_SMALL:  boot_end_of = `FSP_BS_END_768;
        `FSP_BSS_MEDIUM: boot_end_of = `FSP_BS_END_3840;
        `FSP_BSS_LARGE:  boot_end_of = IS_32K ? `FSP_BS_END_7936 : `FSP_BS_END_5376;
        default:         boot_end_of = `FSP_NO_BOOT;
      endcase
    end
  endfunction

  // pair index from channel code, 2'h3 when reserved
  function [1:0] pair_of;
    input [1:0] ics;
    begin
      case (ics)
        `FSP_ICS_PAIR1: pair_of = 2'h0;
        `FSP_ICS_PAIR2: pair_of = 2'h1;
        `FSP_ICS_PAIR3: pair_of = 2'h2;
        default:        pair_of = 2'h3;
      endcase
    end
  endfunction

  // class of one program address against the decoded bounds;
  // the vector test comes before the boot test so a tiny boot end can never shadow it
  function [1:0] class_of;
    input [23:0] addr;
    input [23:0] bend;
    input [23:0] fend;
    begin
      if (addr > fend) begin
        class_of = `FSP_SEG_NONE;
      end else if (addr <= `FSP_VS_END) begin
        class_of = `FSP_SEG_VECTOR;
      end else if (bend != `FSP_NO_BOOT && addr <= bend) begin
        class_of = `FSP_SEG_BOOT;
      end else begin
        class_of = `FSP_SEG_GENERAL;
      end
    end
  endfunction

  // one-hot placement of a single bit on the chosen pair;
  // shared by the data and enable paths so they cannot disagree
  function [2:0] pair_mask;
    input       bit_in;
    input [1:0] idx;
    begin
      case (idx)
        2'h0:    pair_mask = {2'h0, bit_in};
        2'h1:    pair_mask = {1'b0, bit_in, 1'b0};
        2'h2:    pair_mask = {bit_in, 2'h0};
        default: pair_mask = 3'h0;
      endcase
    end
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [2:0] clk_sync;
  wire [2:0] dat_sync;
  wire       master_clear_pin_sync_n;

  // link pins idle low, so a cleared stage matches their rest level
  fsp_sync2 #(
    .WIDTH       (6),
    .RESET_VALUE (`FSP_LINK_IDLE)
  ) u_sync (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .async_in ({prog_debug_data_pin_in, prog_debug_clock_pin}),
    .sync_out ({dat_sync, clk_sync})
  );

  // master clear rests high; clearing it to zero would fake an entry
  // sequence for two cycles after every reset
  fsp_sync2 #(
    .WIDTH       (1),
    .RESET_VALUE (`FSP_MASTER_CLEAR_PIN_IDLE)
  ) u_sync_master_clear_pin (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .async_in (master_clear_pin_n),
    .sync_out (master_clear_pin_sync_n)
  );

  // ----------------------------------------
  // segment decode
  // ----------------------------------------
  wire [23:0] flash_end = IS_32K ? `FSP_END_32K : `FSP_END_16K;
  wire [23:0] bend      = boot_end_of(boot_segment_config[1:0]);
  reg  [1:0]  seg_d;

  // only four classes exist (vector, boot, general, none); nothing secure is decoded
  // the class is registered below, trading a cycle for a flop-driven output
  always @* begin
    seg_d = class_of(prog_addr, bend, flash_end);
  end

  // registered class and protection state
  always @(posedge clk_sys) begin
    if (reset) begin
      segment_class_q   <= `FSP_SEG_VECTOR;
      addr_invalid_q    <= 1'b0;
      boot_protect_q    <= 1'b0;
      general_protect_q <= 1'b0;
      boot_end_q        <= `FSP_NO_BOOT;
    end else begin
      segment_class_q   <= seg_d;
      addr_invalid_q    <= (seg_d == `FSP_SEG_NONE);
      // protection policy bits are active low, as erased config reads ones
      boot_protect_q    <= (seg_d == `FSP_SEG_BOOT) & ~boot_segment_config[3];
      general_protect_q <= (seg_d == `FSP_SEG_GENERAL) & ~general_segment_config[0];
      boot_end_q        <= bend;
    end
  end

  // ----------------------------------------
  // link pin selection and edge finding
  // ----------------------------------------
  wire [1:0] pair   = pair_of(debug_channel_sel);
  wire       pair_ok = (pair != 2'h3);
  wire       sel_clk = pair_ok ? clk_sync[pair] : 1'b0;
  wire       sel_dat = pair_ok ? dat_sync[pair] : 1'b0;

  // edges found from the sampled clock; debugger owns the clock
  // each link clock phase must span at least one system clock or an
  // edge is lost; the pulses trail the pin by three system clocks
  always @(posedge clk_sys) begin
    if (reset) begin
      link_clock_q          <= 1'b0;
      link_clock_rise_q     <= 1'b0;
      link_clock_fall_q     <= 1'b0;
      link_data_q           <= 1'b0;
      master_clear_active_q <= 1'b0;
      channel_error_q       <= 1'b0;
    end else begin
      link_clock_q          <= sel_clk;
      link_clock_rise_q     <= sel_clk & ~link_clock_q;
      link_clock_fall_q     <= ~sel_clk & link_clock_q;
      link_data_q           <= sel_dat;
      master_clear_active_q <= ~master_clear_pin_sync_n;
      channel_error_q       <= ~pair_ok;
    end
  end

  // data pin drive only on the chosen pair; reserved code drives nothing
  // the enable is a flop so the pad never sees a decode glitch, at the
  // price of one cycle between a turnaround request and the pin letting go
  always @(posedge clk_sys) begin
    if (reset) begin
      prog_debug_data_pin_out <= 3'h0;
      prog_debug_data_pin_oe  <= 3'h0;
    end else begin
      prog_debug_data_pin_out <= pair_mask(link_data_out, pair);
      prog_debug_data_pin_oe  <= pair_mask(link_data_oe, pair);
    end
  end

  // ----------------------------------------
  // debugger resource reservation
  // ----------------------------------------
  // only the flags are produced here; the ram and pin owners must honour
  // them while debugging is on, the block does not gate them itself
  always @(posedge clk_sys) begin
    if (reset) begin
      ram_reserved_q  <= 1'b0;
      pins_reserved_q <= 2'h0;
    end else begin
      ram_reserved_q  <= debug_enable & (ram_addr < `FSP_DBG_RAM_BYTES);
      pins_reserved_q <= {2{debug_enable}};
    end
  end

endmodule
`default_nettype wire

//--- logic/fsp_map.vh
`ifndef FSP_MAP_VH
`define FSP_MAP_VH
// ----------------------------------------
// program memory segment boundaries
// ----------------------------------------
`define FSP_VS_END        24'h00_01FE
`define FSP_BS_START      24'h00_0200
`define FSP_BS_END_768    24'h00_07FE
`define FSP_BS_END_3840   24'h00_1FFE
`define FSP_BS_END_7936   24'h00_3FFE
`define FSP_BS_END_5376   24'h00_2BFE
`define FSP_END_32K       24'h00_57FE
`define FSP_END_16K       24'h00_2BFE
// ----------------------------------------
// boot size select codes (low two bits)
// ----------------------------------------
`define FSP_BSS_NONE      2'h3
`define FSP_BSS_SMALL     2'h2
`define FSP_BSS_MEDIUM    2'h1
`define FSP_BSS_LARGE     2'h0
// ----------------------------------------
// debug channel select codes
// ----------------------------------------
`define FSP_ICS_PAIR1     2'h3
`define FSP_ICS_PAIR2     2'h2
`define FSP_ICS_PAIR3     2'h1
`define FSP_ICS_RSVD      2'h0
// ----------------------------------------
// segment class codes
// ----------------------------------------
`define FSP_SEG_VECTOR    2'h0
`define FSP_SEG_BOOT      2'h1
`define FSP_SEG_GENERAL   2'h2
`define FSP_SEG_NONE      2'h3
// ----------------------------------------
// debugger reserved ram
// ----------------------------------------
`define FSP_DBG_RAM_BYTES 16'h0050
// ----------------------------------------
// decode sentinels and synchroniser rest levels
// ----------------------------------------
`define FSP_NO_BOOT       24'h00_0000
`define FSP_LINK_IDLE     6'h00
`define FSP_MASTER_CLEAR_PIN_IDLE     1'h1
`endif

//--- logic/fsp_sync2.v
`default_nettype none
// ----------------------------------------
// two-stage synchroniser for pin levels
// ----------------------------------------
module fsp_sync2 #(
  parameter             WIDTH       = 1,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  input  wire             clk_sys,
  input  wire             reset,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;

  // first stage feeds only the second
  always @(posedge clk_sys) begin
    if (reset) begin
      // stages rest at the pin's idle level so reset fakes no edge
      meta_q   <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

//--- verification/fsp_props_properties.sv
`default_nettype none
// ----------------------------------------
// port checks for segment protection
// ----------------------------------------
module fsp_props (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic [7:0]  boot_segment_config,
  input wire logic [1:0]  debug_channel_sel,
  input wire logic        debug_enable,
  input wire logic [23:0] prog_addr,
  input wire logic [15:0] ram_addr,
  input wire logic [2:0]  prog_debug_data_pin_oe,
  input wire logic [1:0]  segment_class_q,
  input wire logic        boot_protect_q,
  input wire logic [23:0] boot_end_q,
  input wire logic        ram_reserved_q,
  input wire logic [1:0]  pins_reserved_q,
  input wire logic        link_clock_q,
  input wire logic        link_clock_rise_q,
  input wire logic        channel_error_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // decode answers land one cycle after their inputs
  vec_class_a: assert property (prog_addr <= 24'h00_01FE
    |=> segment_class_q == 2'h0) else $error("vector class wrong");
  small_boot_a: assert property (boot_segment_config[1:0] == 2'h2
    |=> boot_end_q == 24'h00_07FE) else $error("boot end wrong");
  no_boot_a: assert property (boot_segment_config[1:0] == 2'h3
    |=> boot_end_q == 24'h00_0000) else $error("boot end not empty");
  boot_prot_a: assert property (boot_protect_q
    |-> segment_class_q == 2'h1) else $error("boot protect outside boot");
  ram_rsv_a: assert property (1'b1 |=> ram_reserved_q ==
    $past(debug_enable && ram_addr < 16'h0050)) else $error("ram reserve wrong");
  pins_rsv_a: assert property (1'b1 |=>
    pins_reserved_q == {2{$past(debug_enable)}}) else $error("pin reserve wrong");
  chan_err_a: assert property (1'b1 |=>
    channel_error_q == $past(debug_channel_sel == 2'h0)) else $error("channel flag wrong");
  // a rise pulse is one cycle wide and the clock is high under it
  rise_pulse_a: assert property (link_clock_rise_q |->
    link_clock_q ##1 !link_clock_rise_q) else $error("rise pulse wrong");
  one_pair_a: assert property ($onehot0(prog_debug_data_pin_oe))
    else $error("more than one pair driven");
endmodule
bind fsp_segment_protect fsp_props u_props (.*);
`default_nettype wire

//--- verification/fsp_prog_model.sv
`default_nettype none
// ----------------------------------------
// external programmer, msb first frames
// ----------------------------------------
module fsp_prog_model (
  input  wire logic       go,
  input  wire logic [1:0] pair,
  input  wire logic [7:0] frame,
  output logic      [2:0] clk_pin,
  output logic      [2:0] dat_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    clk_pin = 3'h0;
    dat_pin = 3'h0;
  end
  // pair and frame are held for the whole frame, as the bench may
  // already point its inputs at the next pair while the last bit ends
  logic [1:0] p;
  logic [7:0] f;
  // clock stands low outside frames; data shows inverse after release
  always @(posedge go) begin
    p = pair;
    f = frame;
    for (int i = 7; i >= 0; i--) begin
      dat_pin[p] = f[i];
      #200 clk_pin[p] = 1'b1;
      #200 clk_pin[p] = 1'b0;
    end
    dat_pin[p] = ~f[0];
  end
endmodule
`default_nettype wire

//--- verification/test_fsp_segment_protect.sv
`default_nettype none
module test_fsp_segment_protect;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, reset = 1, debug_enable = 0, master_clear_pin_n = 1;
  logic link_data_out = 0, link_data_oe = 0, go = 0;
  logic [7:0] boot_segment_config = 8'hFF, general_segment_config = 8'hFF, frm = 0;
  logic [1:0] debug_channel_sel = 2'h3, pair = 0, segment_class_q, pins_reserved_q;
  logic [23:0] prog_addr = 0, boot_end_q;
  logic [1:0] seg16;
  logic [23:0] bend16;
  logic [15:0] ram_addr = 0;
  logic [2:0] prog_debug_clock_pin, prog_debug_data_pin_in, mdat;
  logic [2:0] prog_debug_data_pin_out, prog_debug_data_pin_oe;
  logic addr_invalid_q, boot_protect_q, general_protect_q, ram_reserved_q, link_clock_q;
  logic link_clock_rise_q, link_clock_fall_q, link_data_q, master_clear_active_q;
  logic channel_error_q;
  int n_errors = 0, tests_run = 0;
  always #25 clk_sys = ~clk_sys;
  // wire level: device drive wins where enabled
  assign prog_debug_data_pin_in = (prog_debug_data_pin_oe & prog_debug_data_pin_out)
                                | (~prog_debug_data_pin_oe & mdat);
  fsp_segment_protect #(.IS_32K(1)) u_dut (.*);
  // 16 KB map instance; only its segment answers are compared
  fsp_segment_protect #(.IS_32K(0)) u_dut16 (
    .clk_sys(clk_sys), .reset(reset), .boot_segment_config(boot_segment_config),
    .general_segment_config(general_segment_config),
    .debug_channel_sel(debug_channel_sel), .debug_enable(debug_enable),
    .prog_addr(prog_addr), .ram_addr(ram_addr),
    .prog_debug_clock_pin(prog_debug_clock_pin),
    .prog_debug_data_pin_in(prog_debug_data_pin_in),
    .master_clear_pin_n(master_clear_pin_n), .link_data_out(link_data_out),
    .link_data_oe(link_data_oe), .prog_debug_data_pin_out(), .prog_debug_data_pin_oe(),
    .segment_class_q(seg16), .addr_invalid_q(), .boot_protect_q(), .general_protect_q(),
    .boot_end_q(bend16), .ram_reserved_q(), .pins_reserved_q(), .link_clock_q(),
    .link_clock_rise_q(), .link_clock_fall_q(), .link_data_q(), .master_clear_active_q(),
    .channel_error_q());
  fsp_prog_model u_prog (.go(go), .pair(pair), .frame(frm),
    .clk_pin(prog_debug_clock_pin), .dat_pin(mdat));
  task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  task tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task t_seg;
    logic [23:0] be [4] = '{24'h00_3FFE, 24'h00_1FFE, 24'h00_07FE, 24'h00_0000};
    logic [23:0] be16 [4] = '{24'h00_2BFE, 24'h00_1FFE, 24'h00_07FE, 24'h00_0000};
    for (int c = 0; c < 4; c++) begin
      boot_segment_config = {6'h3F, c[1:0]};
      prog_addr = 24'h00_01FE; tick(1);
      if (c == 0) chk("master_clear_pin idle", 0, master_clear_active_q);
      chk("vector", 0, segment_class_q);
      chk("boot end", be[c], boot_end_q);
      chk("boot end 16k", be16[c], bend16);
      prog_addr = 24'h00_0200; tick(1);
      chk("first", c == 3 ? 2 : 1, segment_class_q);
      chk("first 16k", c == 3 ? 2 : 1, seg16);
      prog_addr = be[c] + 24'h00_0002; tick(1);
      if (c < 3) chk("after boot", 2, segment_class_q);
      prog_addr = 24'h00_2C00; tick(1);
      chk("beyond 16k", 3, seg16);
      prog_addr = 24'h00_5800; tick(1);
      chk("beyond", 3, segment_class_q);
      chk("invalid", 1, addr_invalid_q);
    end
    $display("segments done");
  endtask
  task t_prot;
    boot_segment_config = 8'h02; general_segment_config = 8'h00;
    prog_addr = 24'h00_0300; tick(1);
    chk("boot prot", 1, boot_protect_q);
    prog_addr = 24'h00_4000; tick(1);
    chk("gen prot", 1, general_protect_q);
    general_segment_config = 8'h01; tick(1);
    chk("gen open", 0, general_protect_q);
    $display("protect done");
  endtask
  task t_dbg;
    debug_enable = 1; ram_addr = 16'h004F; tick(1);
    chk("ram 4f", 1, ram_reserved_q);
    chk("pins", 3, pins_reserved_q);
    ram_addr = 16'h0050; tick(1);
    chk("ram 50", 0, ram_reserved_q);
    $display("debug done");
  endtask
  task t_link;
    logic [7:0] rx;
    int cnt, nf;
    for (int k = 0; k < 3; k++) begin
      debug_channel_sel = 2'h3 - k[1:0]; pair = k[1:0]; frm = 8'hA5 ^ k[7:0];
      link_data_oe = 1; link_data_out = 1; master_clear_pin_n = 0; tick(4);
      chk("oe", 3'h1 << k, prog_debug_data_pin_oe);
      chk("out", 3'h1 << k, prog_debug_data_pin_out);
      chk("master_clear_pin", 1, master_clear_active_q);
      link_data_oe = 0; master_clear_pin_n = 1; go = 1; cnt = 0; nf = 0; tick(1);
      go = 0;
      for (int n = 0; n < 200 && cnt < 8; n++) begin
        tick(1);
        if (link_clock_rise_q === 1'b1) begin rx = {rx[6:0], link_data_q}; cnt++; end
        if (link_clock_fall_q === 1'b1) nf++;
      end
      if (cnt < 8) begin n_errors++; print_verdict; end
      chk("frame", frm, rx);
      chk("falls", 7, nf);
      chk("clock high", 1, link_clock_q);
    end
    debug_channel_sel = 2'h0; link_data_oe = 1; tick(2);
    chk("chan err", 1, channel_error_q);
    chk("no drive", 0, prog_debug_data_pin_oe);
    $display("link done");
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    tick(8);
    reset = 0;
    t_seg; t_prot; t_dbg; t_link;
    print_verdict;
  end
endmodule
`default_nettype wire
